// ### hw/rts_regs.sv
// module: register map, result formatting and conversion sequencing of the temperature sensor
`timescale 1ns/100ps

// Behaviour
// - config one at two codes, five bits, reset zero
// - two-bit rate at two codes, resets two
// - one-shot write starts one conversion in standby
// - status one read-only: busy, alarms, fault
// - status two: not-ready and diode type
// - remote limits reset to 85 and 110
// - seven-bit local limit resets to 85
// - local whole byte signed, one degree steps
// - local fraction in bits 7:5, rest zero
// - signed remote whole byte, sign bit seven
// - signed fraction five bits filtered, else three
// - unsigned remote whole byte 0 to 255
// - unsigned fraction same layout as signed
// - whole-byte read freezes matching fraction byte
// - fraction read releases; repeat whole read refreezes
// - diode config bit 6 selects pin function
// - bits 5 and 4 mask diode fault
// - bit 3 selects remote diode model
// - bits 2:1 filter off 00, on 11
// - bit 7 reads 0, bit 0 reads 1, reset 1F
// - signed offset, eighth-degree fraction, reset zero
// - unused bits read zero, except diode config bit 0
// - standby bit halts periodic conversions
// - rate codes: continuous, 0.364, 1, 2.5 s
// - five-bit hysteresis resets to ten
module rts_regs #(
	parameter int unsigned P_READY_CYC = rts_pkg::READY_CYC,
	parameter int unsigned P_RATE1_CYC = rts_pkg::RATE1_CYC,
	parameter int unsigned P_RATE2_CYC = rts_pkg::RATE2_CYC,
	parameter int unsigned P_RATE3_CYC = rts_pkg::RATE3_CYC,
	parameter logic [7:0] P_MAKER_CODE = 8'h5A, // arbitrary value
	parameter logic [7:0] P_REVISION = 8'h3C // arbitrary value
) (
	// core clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// register access from the serial bus engine, link clock domain
	input wire logic i_link_clk,
	input wire logic i_lk_wr,
	input wire logic i_lk_rd,
	input wire logic [7:0] i_lk_cmd,
	input wire logic [7:0] i_lk_wdata,
	output logic [7:0] o_lk_rdata,
	output logic o_lk_done,
	output logic o_lk_busy,
	// measurement front end
	input wire logic i_conv_done,
	input wire logic [10:0] i_local_raw,
	input wire logic [13:0] i_remote_raw,
	input wire rts_pkg::rts_meas_s i_meas,
	output logic o_conv_start,
	output logic o_busy,
	// configuration towards comparators and pins
	output rts_pkg::rts_cfg_s o_cfg
);

	// ==========================================
	// helpers
	function automatic logic [31:0] rem_fmt(input logic [13:0] raw, input logic [7:0] off_hi,
		input logic [2:0] off_lo, input logic filt, input logic fault);
		logic signed [14:0] off;
		logic signed [14:0] sum;
		logic [12:0] s;
		logic [12:0] u;
		logic [7:0] sl;
		logic [7:0] ul;
		off = $signed({{2{off_hi[7]}}, off_hi, off_lo, 2'h0});
		sum = $signed({raw[13], raw}) + off;
		if (sum > 15'sh0FFF) begin
			s = 13'h0FFF;
		end else if (sum < -15'sh1000) begin
			s = 13'h1000;
		end else begin
			s = sum[12:0];
		end
		if (sum < 15'sh0000) begin
			u = 13'h0000;
		end else if (sum > 15'sh1FFF) begin
			u = 13'h1FFF;
		end else begin
			u = sum[12:0];
		end
		sl = {s[4:0], 3'h0} & (filt ? rts_pkg::FRAC5_MASK : rts_pkg::FRAC3_MASK);
		ul = {u[4:0], 3'h0} & (filt ? rts_pkg::FRAC5_MASK : rts_pkg::FRAC3_MASK);
		if (fault) begin
			rem_fmt = {8'h80, 8'h00, 8'hFF, rts_pkg::FRAC3_MASK};
		end else begin
			rem_fmt = {s[12:5], sl, u[12:5], ul};
		end
	endfunction

	function automatic logic [31:0] rate_limit(input logic [1:0] code);
		case (code)
			2'h0: rate_limit = 32'h0000_0000;
			2'h1: rate_limit = P_RATE1_CYC;
			2'h2: rate_limit = P_RATE2_CYC;
			default: rate_limit = P_RATE3_CYC;
		endcase
	endfunction

	// ==========================================
	// link side: hold one request until the core answers
	rts_pkg::rts_link_s lk_r;
	rts_pkg::rts_link_s lk_nxt;
	rts_pkg::rts_core_s c_r;
	rts_pkg::rts_core_s c_nxt;

	always_comb begin
		lk_nxt = lk_r;
		lk_nxt.done = 1'b0;
		lk_nxt.ack_s1 = c_r.ack_tog;
		lk_nxt.ack_s2 = lk_r.ack_s1;
		lk_nxt.ack_s3 = lk_r.ack_s2;
		if (lk_r.ack_s2 ^ lk_r.ack_s3) begin
			// core rdata has been stable since the ack toggled
			lk_nxt.rdata = c_r.rdata;
			lk_nxt.done = 1'b1;
			lk_nxt.busy = 1'b0;
		end else if (!lk_r.busy && (i_lk_wr || i_lk_rd)) begin
			lk_nxt.cmd = i_lk_cmd;
			lk_nxt.wr = i_lk_wr;
			lk_nxt.wdata = i_lk_wdata;
			lk_nxt.req_tog = ~lk_r.req_tog;
			lk_nxt.busy = 1'b1;
		end
	end

	always_ff @(posedge i_link_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lk_r <= '0;
		end else begin
			lk_r <= lk_nxt;
		end
	end

	assign o_lk_rdata = lk_r.rdata;
	assign o_lk_done = lk_r.done;
	assign o_lk_busy = lk_r.busy;

	// ==========================================
	// core side: register file, locks, sequencer
	logic acc;
	logic [31:0] rfmt;
	logic filt_on;
	logic standby;
	logic start;
	logic [7:0] rd_val;

	assign acc = c_r.req_s2 ^ c_r.req_s3;
	assign filt_on = (c_r.dcfg[rts_pkg::DCFG_FILT_HI:rts_pkg::DCFG_FILT_LO] == rts_pkg::FILT_ON);
	assign standby = c_r.cfg1[rts_pkg::CFG1_STANDBY_BIT];
	assign rfmt = rem_fmt(i_remote_raw, c_r.off_hi, c_r.off_lo, filt_on, i_meas.diode_fault);

	always_comb begin
		case (lk_r.cmd)
			rts_pkg::CMD_LOC_MSB: rd_val = c_r.loc_msb;
			rts_pkg::CMD_LOC_LSB: rd_val = c_r.loc_lock ? c_r.loc_shadow : c_r.loc_lsb;
			rts_pkg::CMD_RS_MSB: rd_val = c_r.rs_msb;
			rts_pkg::CMD_RS_LSB: rd_val = c_r.rs_lock ? c_r.rs_shadow : c_r.rs_lsb;
			rts_pkg::CMD_RU_MSB: rd_val = c_r.ru_msb;
			rts_pkg::CMD_RU_LSB: rd_val = c_r.ru_lock ? c_r.ru_shadow : c_r.ru_lsb;
			rts_pkg::CMD_STAT1: rd_val = {c_r.conv == rts_pkg::CV_BUSY, 2'h0, i_meas.remote_os, 1'b0,
				i_meas.diode_fault, i_meas.remote_crit, i_meas.local_alarm};
			rts_pkg::CMD_STAT2: rd_val = {c_r.ready_cnt != 32'h0000_0000, i_meas.model_detect, 6'h00};
			rts_pkg::CMD_CFG1_A, rts_pkg::CMD_CFG1_B: rd_val = c_r.cfg1;
			rts_pkg::CMD_RATE_A, rts_pkg::CMD_RATE_B: rd_val = {6'h00, c_r.rate};
			rts_pkg::CMD_ROS_A, rts_pkg::CMD_ROS_B: rd_val = c_r.ros_lim;
			rts_pkg::CMD_RCRIT: rd_val = c_r.rcrit_lim;
			rts_pkg::CMD_LOC_LIM: rd_val = {1'b0, c_r.loc_lim};
			rts_pkg::CMD_HYST: rd_val = {3'h0, c_r.hyst};
			rts_pkg::CMD_DCFG: rd_val = c_r.dcfg | rts_pkg::DCFG_FIXED_ONE;
			rts_pkg::CMD_OFF_HI: rd_val = c_r.off_hi;
			rts_pkg::CMD_OFF_LO: rd_val = {c_r.off_lo, 5'h00};
			rts_pkg::CMD_MAKER: rd_val = P_MAKER_CODE;
			rts_pkg::CMD_REV: rd_val = P_REVISION;
			default: rd_val = 8'h00;
		endcase
	end

	// periodic starts stop in standby; one-shot only honoured in standby
	assign start = (c_r.conv == rts_pkg::CV_IDLE) &&
		(c_r.pend || (!standby && (c_r.ival_cnt >= rate_limit(c_r.rate))));

	always_comb begin
		c_nxt = c_r;
		c_nxt.req_s1 = lk_r.req_tog;
		c_nxt.req_s2 = c_r.req_s1;
		c_nxt.req_s3 = c_r.req_s2;
		c_nxt.conv_start = start;
		if (c_r.ready_cnt != 32'h0000_0000) begin
			c_nxt.ready_cnt = c_r.ready_cnt - 32'h0000_0001;
		end
		// sequencer
		case (c_r.conv)
			rts_pkg::CV_IDLE: begin
				if (start) begin
					c_nxt.conv = rts_pkg::CV_BUSY;
					c_nxt.pend = 1'b0;
					c_nxt.ival_cnt = 32'h0000_0000;
				end else if (!standby && c_r.ival_cnt != 32'hFFFF_FFFF) begin
					c_nxt.ival_cnt = c_r.ival_cnt + 32'h0000_0001;
				end
			end
			rts_pkg::CV_BUSY: begin
				if (i_conv_done) begin
					c_nxt.conv = rts_pkg::CV_IDLE;
					c_nxt.ival_cnt = 32'h0000_0000;
					c_nxt.loc_msb = i_local_raw[10:3];
					c_nxt.loc_lsb = {i_local_raw[2:0], 5'h00};
					{c_nxt.rs_msb, c_nxt.rs_lsb, c_nxt.ru_msb, c_nxt.ru_lsb} = rfmt;
				end
			end
			default: c_nxt.conv = rts_pkg::CV_IDLE;
		endcase
		// register access
		if (acc) begin
			c_nxt.ack_tog = ~c_r.ack_tog;
			if (lk_r.wr) begin
				case (lk_r.cmd)
					rts_pkg::CMD_CFG1_A, rts_pkg::CMD_CFG1_B: c_nxt.cfg1 = lk_r.wdata & rts_pkg::CFG1_MASK;
					rts_pkg::CMD_RATE_A, rts_pkg::CMD_RATE_B: c_nxt.rate = lk_r.wdata[1:0];
					rts_pkg::CMD_ROS_A, rts_pkg::CMD_ROS_B: c_nxt.ros_lim = lk_r.wdata;
					rts_pkg::CMD_RCRIT: c_nxt.rcrit_lim = lk_r.wdata;
					rts_pkg::CMD_LOC_LIM: c_nxt.loc_lim = lk_r.wdata[6:0];
					rts_pkg::CMD_HYST: c_nxt.hyst = lk_r.wdata[4:0];
					rts_pkg::CMD_DCFG: c_nxt.dcfg = lk_r.wdata & rts_pkg::DCFG_MASK;
					rts_pkg::CMD_OFF_HI: c_nxt.off_hi = lk_r.wdata;
					rts_pkg::CMD_OFF_LO: c_nxt.off_lo = lk_r.wdata[7:5];
					rts_pkg::CMD_ONESHOT: c_nxt.pend = standby | c_nxt.pend;
					default: c_nxt.rdata = c_r.rdata;
				endcase
			end else begin
				c_nxt.rdata = rd_val;
				case (lk_r.cmd)
					rts_pkg::CMD_LOC_MSB: begin
						c_nxt.loc_shadow = c_r.loc_lsb;
						c_nxt.loc_lock = 1'b1;
					end
					rts_pkg::CMD_RS_MSB: begin
						c_nxt.rs_shadow = c_r.rs_lsb;
						c_nxt.rs_lock = 1'b1;
					end
					rts_pkg::CMD_RU_MSB: begin
						c_nxt.ru_shadow = c_r.ru_lsb;
						c_nxt.ru_lock = 1'b1;
					end
					rts_pkg::CMD_LOC_LSB: c_nxt.loc_lock = 1'b0;
					rts_pkg::CMD_RS_LSB: c_nxt.rs_lock = 1'b0;
					rts_pkg::CMD_RU_LSB: c_nxt.ru_lock = 1'b0;
					default: c_nxt.rdata = rd_val;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			c_r <= '0;
			c_r.cfg1 <= rts_pkg::CFG1_RST;
			c_r.rate <= rts_pkg::RATE_RST;
			c_r.ros_lim <= rts_pkg::ROS_RST;
			c_r.rcrit_lim <= rts_pkg::RCRIT_RST;
			c_r.loc_lim <= rts_pkg::LOC_LIM_RST;
			c_r.hyst <= rts_pkg::HYST_RST;
			c_r.dcfg <= rts_pkg::DCFG_RST & rts_pkg::DCFG_MASK;
			c_r.off_hi <= rts_pkg::OFF_RST;
			c_r.off_lo <= 3'h0;
			c_r.conv <= rts_pkg::CV_IDLE;
			c_r.ready_cnt <= P_READY_CYC;
		end else begin
			c_r <= c_nxt;
		end
	end

	assign o_conv_start = c_r.conv_start;
	assign o_busy = (c_r.conv == rts_pkg::CV_BUSY);
	// one assignment for the whole struct: a single driver for the output variable
	assign o_cfg = '{
		standby: c_r.cfg1[rts_pkg::CFG1_STANDBY_BIT],
		alarm_mask: c_r.cfg1[4:1],
		pin_is_alarm: c_r.dcfg[rts_pkg::DCFG_PIN_BIT],
		os_fault_mask: c_r.dcfg[rts_pkg::DCFG_OSMASK_BIT],
		crit_fault_mask: c_r.dcfg[rts_pkg::DCFG_CRITMASK_BIT],
		model_proc: c_r.dcfg[rts_pkg::DCFG_MODEL_BIT],
		filter_ctrl: c_r.dcfg[rts_pkg::DCFG_FILT_HI:rts_pkg::DCFG_FILT_LO],
		remote_overtemp_limit: c_r.ros_lim,
		remote_crit_limit: c_r.rcrit_lim,
		local_limit: c_r.loc_lim,
		hysteresis: c_r.hyst
	};

	// ==========================================
	// checks
	AST_CFG1_UNUSED_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && lk_r.wr && lk_r.cmd == rts_pkg::CMD_CFG1_B |=> c_r.cfg1 == ($past(lk_r.wdata) & 8'h5E))
		else $error("config one write not stored as masked");
	AST_ONESHOT_START: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && lk_r.wr && lk_r.cmd == rts_pkg::CMD_ONESHOT && standby && o_busy && !i_conv_done
		|=> c_r.pend)
		else $error("one-shot request lost");
	AST_STANDBY_HALT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$rose(o_conv_start) |-> $past(c_r.pend) || !$past(standby))
		else $error("conversion started in standby without one-shot");
	AST_RO_WRITE_IGNORED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && lk_r.wr && lk_r.cmd == rts_pkg::CMD_STAT1 |=> $stable(c_r.cfg1) && $stable(c_r.dcfg) && $stable(c_r.ros_lim))
		else $error("write to read-only code changed state");
	AST_MSB_LOCKS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && !lk_r.wr && lk_r.cmd == rts_pkg::CMD_RS_MSB |=> c_r.rs_lock && c_r.rs_shadow == $past(c_r.rs_lsb))
		else $error("signed fraction not frozen by whole read");
	AST_LSB_RELEASES: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && !lk_r.wr && lk_r.cmd == rts_pkg::CMD_RU_LSB |=> !c_r.ru_lock)
		else $error("unsigned fraction lock not released");
	AST_FILTER_OFF_FRAC: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && !lk_r.wr && lk_r.cmd == rts_pkg::CMD_RS_LSB && !filt_on && !c_r.rs_lock |=> c_r.rdata[4:0] == 5'h00)
		else $error("fraction bits below eighth degree with filter off");
	AST_DCFG_FIXED_BITS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && !lk_r.wr && lk_r.cmd == rts_pkg::CMD_DCFG |=> !c_r.rdata[7] && c_r.rdata[0])
		else $error("diode config fixed bits wrong");
	AST_NOT_READY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && !lk_r.wr && lk_r.cmd == rts_pkg::CMD_STAT2 && c_r.ready_cnt > 32'h0000_0001 |=> c_r.rdata[7])
		else $error("not-ready flag clear during power-up interval");
	AST_LOCAL_LIMIT_7B: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && !lk_r.wr && lk_r.cmd == rts_pkg::CMD_LOC_LIM |=> c_r.rdata[7] == 1'b0)
		else $error("local limit bit seven not zero");
	// busy may only drop on a finished conversion, never on its own
	AST_BUSY_STATUS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_busy && !i_conv_done |=> o_busy)
		else $error("busy not held through conversion");
	AST_STAT1_BUSY_BIT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && !lk_r.wr && lk_r.cmd == rts_pkg::CMD_STAT1 |=> c_r.rdata[7] == $past(o_busy) && c_r.rdata[6:5] == 2'h0)
		else $error("status one busy bit wrong");
	AST_RATE_STORE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && lk_r.wr && lk_r.cmd == rts_pkg::CMD_RATE_A |=> c_r.rate == $past(lk_r.wdata[1:0]))
		else $error("rate write not stored");
	AST_RATE_READ_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && !lk_r.wr && lk_r.cmd == rts_pkg::CMD_RATE_B |=> c_r.rdata[7:2] == 6'h00)
		else $error("rate unused bits not zero");
	AST_LOC_LIMIT_STORE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && lk_r.wr && lk_r.cmd == rts_pkg::CMD_LOC_LIM |=> c_r.loc_lim == $past(lk_r.wdata[6:0]))
		else $error("local limit write not stored");
	AST_HYST_STORE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && lk_r.wr && lk_r.cmd == rts_pkg::CMD_HYST |=> c_r.hyst == $past(lk_r.wdata[4:0]))
		else $error("hysteresis write not stored");
	AST_DCFG_STORE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && lk_r.wr && lk_r.cmd == rts_pkg::CMD_DCFG |=> c_r.dcfg == ($past(lk_r.wdata) & rts_pkg::DCFG_MASK))
		else $error("diode config write not stored");
	AST_OFFSET_LO_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && !lk_r.wr && lk_r.cmd == rts_pkg::CMD_OFF_LO |=> c_r.rdata[4:0] == 5'h00)
		else $error("offset fraction unused bits not zero");
	AST_LOC_FRAC_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		acc && !lk_r.wr && lk_r.cmd == rts_pkg::CMD_LOC_LSB |=> c_r.rdata[4:0] == 5'h00)
		else $error("local fraction unused bits not zero");
	// a frozen fraction must survive new conversions until it is read
	AST_LOCK_KEEPS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		c_r.rs_lock && !(acc && !lk_r.wr) |=> c_r.rs_lock && $stable(c_r.rs_shadow))
		else $error("frozen signed fraction disturbed");

endmodule

// ### hw/rts_pkg.sv
// package: command codes, field layouts, reset values and timing of the temperature sensor register block
package rts_pkg;

	// ==========================================
	// command codes
	localparam logic [7:0] CMD_LOC_MSB = 8'h00;
	localparam logic [7:0] CMD_RS_MSB = 8'h01;
	localparam logic [7:0] CMD_STAT1 = 8'h02;
	localparam logic [7:0] CMD_CFG1_A = 8'h03;
	localparam logic [7:0] CMD_CFG1_B = 8'h09;
	localparam logic [7:0] CMD_RATE_A = 8'h04;
	localparam logic [7:0] CMD_RATE_B = 8'h0A;
	localparam logic [7:0] CMD_ROS_A = 8'h07;
	localparam logic [7:0] CMD_ROS_B = 8'h0D;
	localparam logic [7:0] CMD_ONESHOT = 8'h0F;
	localparam logic [7:0] CMD_RS_LSB = 8'h10;
	localparam logic [7:0] CMD_OFF_HI = 8'h11;
	localparam logic [7:0] CMD_OFF_LO = 8'h12;
	localparam logic [7:0] CMD_RCRIT = 8'h19;
	localparam logic [7:0] CMD_LOC_LIM = 8'h20;
	localparam logic [7:0] CMD_HYST = 8'h21;
	localparam logic [7:0] CMD_LOC_LSB = 8'h30;
	localparam logic [7:0] CMD_RU_MSB = 8'h31;
	localparam logic [7:0] CMD_RU_LSB = 8'h32;
	localparam logic [7:0] CMD_STAT2 = 8'h33;
	localparam logic [7:0] CMD_DCFG = 8'hBF;
	localparam logic [7:0] CMD_MAKER = 8'hFE;
	localparam logic [7:0] CMD_REV = 8'hFF;

	// ==========================================
	// field layouts and masks
	localparam logic [7:0] CFG1_MASK = 8'h5E;
	localparam int CFG1_STANDBY_BIT = 6;
	localparam logic [7:0] DCFG_MASK = 8'h7E;
	localparam logic [7:0] DCFG_FIXED_ONE = 8'h01;
	localparam int DCFG_PIN_BIT = 6;
	localparam int DCFG_OSMASK_BIT = 5;
	localparam int DCFG_CRITMASK_BIT = 4;
	localparam int DCFG_MODEL_BIT = 3;
	localparam int DCFG_FILT_HI = 2;
	localparam int DCFG_FILT_LO = 1;
	localparam logic [1:0] FILT_ON = 2'h3;
	localparam logic [7:0] FRAC3_MASK = 8'hE0;
	localparam logic [7:0] FRAC5_MASK = 8'hF8;

	// ==========================================
	// values after reset
	localparam logic [7:0] CFG1_RST = 8'h00;
	localparam logic [1:0] RATE_RST = 2'h2;
	localparam logic [7:0] ROS_RST = 8'h55;
	localparam logic [7:0] RCRIT_RST = 8'h6E;
	localparam logic [6:0] LOC_LIM_RST = 7'h55;
	localparam logic [4:0] HYST_RST = 5'h0A;
	localparam logic [7:0] DCFG_RST = 8'h1F;
	localparam logic [7:0] OFF_RST = 8'h00;

	// ==========================================
	// timing at 100 MHz
	localparam int unsigned CLK_KHZ = 100000;
	localparam int unsigned READY_MS = 30;
	localparam int unsigned RATE1_US = 364000;
	localparam int unsigned RATE2_MS = 1000;
	localparam int unsigned RATE3_MS = 2500;
	localparam int unsigned READY_CYC = READY_MS * CLK_KHZ;
	localparam int unsigned RATE1_CYC = (RATE1_US / 1000) * CLK_KHZ + ((RATE1_US % 1000) * CLK_KHZ) / 1000;
	localparam int unsigned RATE2_CYC = RATE2_MS * CLK_KHZ;
	localparam int unsigned RATE3_CYC = RATE3_MS * CLK_KHZ;

	// ==========================================
	// types
	typedef enum logic {CV_IDLE, CV_BUSY} rts_conv_e;

	typedef struct packed {
		logic remote_os;
		logic remote_crit;
		logic local_alarm;
		logic diode_fault;
		logic model_detect;
	} rts_meas_s;

	typedef struct packed {
		logic standby;
		logic [3:0] alarm_mask;
		logic pin_is_alarm;
		logic os_fault_mask;
		logic crit_fault_mask;
		logic model_proc;
		logic [1:0] filter_ctrl;
		logic [7:0] remote_overtemp_limit;
		logic [7:0] remote_crit_limit;
		logic [6:0] local_limit;
		logic [4:0] hysteresis;
	} rts_cfg_s;

	typedef struct packed {
		logic req_tog;
		logic [7:0] cmd;
		logic wr;
		logic [7:0] wdata;
		logic busy;
		logic ack_s1;
		logic ack_s2;
		logic ack_s3;
		logic [7:0] rdata;
		logic done;
	} rts_link_s;

	typedef struct packed {
		logic req_s1;
		logic req_s2;
		logic req_s3;
		logic ack_tog;
		logic [7:0] rdata;
		logic [7:0] cfg1;
		logic [1:0] rate;
		logic [7:0] ros_lim;
		logic [7:0] rcrit_lim;
		logic [6:0] loc_lim;
		logic [4:0] hyst;
		logic [7:0] dcfg;
		logic [7:0] off_hi;
		logic [2:0] off_lo;
		logic [7:0] loc_msb;
		logic [7:0] loc_lsb;
		logic [7:0] rs_msb;
		logic [7:0] rs_lsb;
		logic [7:0] ru_msb;
		logic [7:0] ru_lsb;
		logic [7:0] loc_shadow;
		logic [7:0] rs_shadow;
		logic [7:0] ru_shadow;
		logic loc_lock;
		logic rs_lock;
		logic ru_lock;
		rts_conv_e conv;
		logic pend;
		logic conv_start;
		logic [31:0] ival_cnt;
		logic [31:0] ready_cnt;
	} rts_core_s;

endpackage

// ### testbench/rts_fe_model.sv
// front-end model: answers conversion starts with raw results after a set delay
`timescale 1ns/100ps
module rts_fe_model (
	// core side
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic [15:0] i_dly,
	input wire logic [10:0] i_loc,
	input wire logic [13:0] i_rem,
	// answer
	output logic o_done,
	output logic [10:0] o_loc,
	output logic [13:0] o_rem
);
	int cnt;
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt <= 0;
			o_done <= 1'b0;
		end else begin
			o_done <= (cnt == 1);
			if (i_start)
				cnt <= int'(i_dly) + 1;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
	// results valid only in the done cycle; inverted otherwise so a late sample shows
	assign o_loc = o_done ? i_loc : ~i_loc;
	assign o_rem = o_done ? i_rem : ~i_rem;
endmodule

// ### testbench/test_rts_regs.sv
// testbench: register link, result formats and conversion sequencing of the sensor block
`timescale 1ns/100ps
module test_rts_regs;
	// ==========================================
	// signals
	localparam logic [7:0] MAKER = 8'h4D; // arbitrary value
	localparam logic [7:0] REV = 8'h27; // arbitrary value
	logic clk = 1'b0;
	logic lclk = 1'b0;
	logic rst_n = 1'b0;
	logic lk_wr = 1'b0;
	logic lk_rd = 1'b0;
	logic [7:0] lk_cmd = 8'h00;
	logic [7:0] lk_wd = 8'h00;
	logic [7:0] lk_rdata;
	logic lk_done;
	logic lk_busy;
	logic conv_done;
	logic [10:0] loc_raw;
	logic [13:0] rem_raw;
	logic [10:0] loc_v = 11'h000;
	logic [13:0] rem_v = 14'h0000;
	logic [15:0] dly = 16'h0064;
	rts_pkg::rts_meas_s meas = 5'b00001;
	logic conv_start;
	logic busy;
	rts_pkg::rts_cfg_s cfg;
	logic [7:0] q;
	int failures = 0;
	int comparisons = 0;
	int conv_cnt = 0;

	always #5 clk = ~clk;
	// link clock runs at 32 ns, offset so two of its rising edges fall inside reset
	initial begin
		#3;
		lclk = 1'b1;
		forever #16 lclk = ~lclk;
	end
	always @(negedge clk)
		if (conv_start === 1'b1)
			conv_cnt++;

	rts_regs #(.P_READY_CYC(200), .P_RATE1_CYC(40), .P_RATE2_CYC(60), .P_RATE3_CYC(80),
		.P_MAKER_CODE(MAKER), .P_REVISION(REV)) dut (
		.i_clk(clk), .i_rst_n(rst_n), .i_link_clk(lclk), .i_lk_wr(lk_wr), .i_lk_rd(lk_rd),
		.i_lk_cmd(lk_cmd), .i_lk_wdata(lk_wd), .o_lk_rdata(lk_rdata), .o_lk_done(lk_done),
		.o_lk_busy(lk_busy), .i_conv_done(conv_done), .i_local_raw(loc_raw), .i_remote_raw(rem_raw),
		.i_meas(meas), .o_conv_start(conv_start), .o_busy(busy), .o_cfg(cfg));
	rts_fe_model fe (.i_clk(clk), .i_rst_n(rst_n), .i_start(conv_start), .i_dly(dly),
		.i_loc(loc_v), .i_rem(rem_v), .o_done(conv_done), .o_loc(loc_raw), .o_rem(rem_raw));

	// ==========================================
	// shared tasks
	task automatic complete_run();
		if (failures == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic fail_out();
		failures++;
		complete_run();
	endtask
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// request held until the edge that takes it, answer taken in the done cycle
	task automatic acc(input logic w, input logic [7:0] c, input logic [7:0] d, output logic [7:0] r);
		int n;
		@(posedge lclk);
		#1;
		lk_wr = w;
		lk_rd = !w;
		lk_cmd = c;
		lk_wd = d;
		@(posedge lclk);
		#1;
		lk_wr = 1'b0;
		lk_rd = 1'b0;
		n = 0;
		while (lk_done !== 1'b1 && n < 40) begin
			@(posedge lclk);
			#1;
			n++;
		end
		if (n == 40)
			fail_out();
		r = lk_rdata;
	endtask
	task automatic rdc(input logic [7:0] c, input logic [7:0] e);
		acc(1'b0, c, 8'h00, q);
		chk8($sformatf("reg %h", c), e, q);
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		acc(1'b1, c, d, q);
	endtask
	task automatic idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 2000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 2000)
			fail_out();
	endtask
	task automatic conv(input logic [10:0] l, input logic [13:0] r);
		int c0;
		int n;
		idle();
		c0 = conv_cnt;
		loc_v = l;
		rem_v = r;
		wr(8'h0F, 8'hA5);
		n = 0;
		while (!(conv_cnt == c0 + 1 && busy === 1'b0) && n < 2000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 2000)
			fail_out();
		repeat (200) @(posedge clk);
		chk8("one-shot starts", 8'h01, 8'(conv_cnt - c0));
	endtask
	task automatic gap(output int g);
		int n;
		n = 0;
		while (conv_done !== 1'b1 && n < 1000) begin
			@(posedge clk);
			#1;
			n++;
		end
		g = 0;
		while (conv_start !== 1'b1 && g < 1000) begin
			@(posedge clk);
			#1;
			g++;
		end
		if (n == 1000 || g == 1000)
			fail_out();
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset();
		rdc(8'h33, 8'hC0);
		rdc(8'h03, 8'h00);
		rdc(8'h09, 8'h00);
		rdc(8'h04, 8'h02);
		rdc(8'h0A, 8'h02);
		rdc(8'h07, 8'h55);
		rdc(8'h0D, 8'h55);
		rdc(8'h19, 8'h6E);
		rdc(8'h20, 8'h55);
		rdc(8'h21, 8'h0A);
		rdc(8'hBF, 8'h1F);
		rdc(8'h11, 8'h00);
		rdc(8'h12, 8'h00);
		rdc(8'hFE, MAKER);
		rdc(8'hFF, REV);
	endtask
	task automatic t_masks();
		logic [7:0] wc[9] = '{8'h03, 8'h0A, 8'h0D, 8'h19, 8'h20, 8'h21, 8'hBF, 8'h11, 8'h12};
		logic [7:0] rc[9] = '{8'h09, 8'h04, 8'h07, 8'h19, 8'h20, 8'h21, 8'hBF, 8'h11, 8'h12};
		logic [7:0] em[9] = '{8'h5E, 8'h03, 8'hFF, 8'hFF, 8'h7F, 8'h1F, 8'h7F, 8'hFF, 8'hE0};
		for (int i = 0; i < 9; i++) begin
			wr(wc[i], 8'hFF);
			rdc(rc[i], em[i]);
		end
		chk8("cfg fields", 8'hFF, {cfg.standby, cfg.alarm_mask, cfg.pin_is_alarm, cfg.os_fault_mask,
			cfg.crit_fault_mask});
		chk8("cfg local limit", 8'h7F, {1'b0, cfg.local_limit});
		chk8("cfg remote limit", 8'hFF, cfg.remote_overtemp_limit);
		chk8("cfg crit limit", 8'hFF, cfg.remote_crit_limit);
		chk8("cfg hysteresis", 8'h1F, {3'h0, cfg.hysteresis});
		chk8("cfg filter", 8'h03, {6'h00, cfg.filter_ctrl});
		for (int i = 0; i < 9; i++) begin
			wr(wc[i], 8'h00);
			rdc(rc[i], (wc[i] == 8'hBF) ? 8'h01 : 8'h00);
		end
		chk8("cfg model", 8'h00, {cfg.model_proc, cfg.pin_is_alarm, cfg.filter_ctrl, 4'h0});
		wr(8'h03, 8'h40);
		wr(8'h04, 8'h02);
		wr(8'hBF, 8'h1F);
	endtask
	task automatic t_status();
		meas = 5'b11010;
		idle();
		wr(8'h0F, 8'h00);
		rdc(8'h02, 8'h96);
		wr(8'h02, 8'hFF);
		idle();
		rdc(8'h02, 8'h16);
		rdc(8'h33, 8'h00);
		meas = 5'b00001;
	endtask
	task automatic t_results();
		conv(11'h0CD, 14'h0799);
		rdc(8'h00, 8'h19);
		rdc(8'h30, 8'hA0);
		rdc(8'h01, 8'h3C);
		rdc(8'h31, 8'h3C);
		wr(8'h11, 8'h02);
		wr(8'h12, 8'h20);
		conv(11'h0CD, 14'h0783);
		rdc(8'h10, 8'hC8);
		rdc(8'h10, 8'h38);
		rdc(8'h32, 8'hC8);
		rdc(8'h31, 8'h3E);
		rdc(8'h01, 8'h3E);
		wr(8'hBF, 8'h19);
		conv(11'h7E6, 14'h3EB0);
		rdc(8'h10, 8'h38);
		rdc(8'h10, 8'hA0);
		rdc(8'h00, 8'hFC);
		rdc(8'h30, 8'hC0);
		rdc(8'h01, 8'hF7);
		rdc(8'h31, 8'h00);
		rdc(8'h32, 8'h00);
	endtask
	task automatic t_ro();
		logic [7:0] ro[10] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h30, 8'h31, 8'h32, 8'h33, 8'hFE, 8'hFF};
		foreach (ro[i])
			wr(ro[i], 8'h77);
		rdc(8'hFE, MAKER);
		rdc(8'hFF, REV);
		rdc(8'h03, 8'h40);
		rdc(8'h00, 8'hFC);
		rdc(8'h0F, 8'h00);
		rdc(8'h50, 8'h00);
		chk8("link busy", 8'h00, {7'h00, lk_busy});
	endtask
	task automatic t_rate();
		int lim[4] = '{0, 40, 60, 80};
		int g;
		dly = 16'h0005;
		wr(8'h03, 8'h00);
		for (int r = 0; r < 4; r++) begin
			wr(8'h04, 8'(r));
			gap(g);
			gap(g);
			chk8("rate gap", 8'h01, 8'(g + 1 >= lim[r] && g <= lim[r] + 4));
		end
		wr(8'h03, 8'h40);
		idle();
		g = conv_cnt;
		repeat (300) @(posedge clk);
		chk8("standby starts", 8'h00, 8'(conv_cnt - g));
	endtask

	initial begin
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_reset();
		t_masks();
		t_status();
		t_results();
		t_ro();
		t_rate();
		complete_run();
	end
endmodule
